/* verilog/uart_flags_pkg.sv */
// constants for the serial port flag, divisor and sir clock block
package uart_flags_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_DATA_PORT   = 12'h000;
   localparam logic [11:0] OFS_FIFO_FLAGS  = 12'h018;
   localparam logic [11:0] OFS_IRDA_LP_DIV = 12'h020;
   localparam logic [11:0] OFS_BAUD_INT    = 12'h024;
   localparam logic [11:0] OFS_BAUD_BAUD_VALUE_A   = 12'h028;
   localparam logic [11:0] OFS_LINE_CTRL   = 12'h02c;
   localparam logic [11:0] OFS_IRQ_STATUS  = 12'h040;
   localparam logic [11:0] OFS_IRQ_MASK    = 12'h044;

   // flag register field positions
   localparam int TX_EMPTY_BIT = 7;
   localparam int RX_FULL_BIT  = 6;
   localparam int TX_FULL_BIT  = 5;
   localparam int RX_EMPTY_BIT = 4;
   localparam int BUSY_BIT     = 3;

   // line control field position
   localparam int BUFFER_MODE_BIT = 4;

   // interrupt status field positions
   localparam int IRQ_TX_DRAINED_BIT = 0;
   localparam int IRQ_RX_DATA_BIT    = 1;
   localparam int IRQ_RX_OVERRUN_BIT = 2;
   localparam int IRQ_BITS           = 3;

   // field widths
   localparam int LP_DIV_W    = 8;
   localparam int BAUD_INT_W  = 16;
   localparam int BAUD_BAUD_VALUE_A_W = 6;

   // reset values
   localparam logic [LP_DIV_W-1:0]    LP_DIV_RESET    = 8'h00;
   localparam logic [BAUD_INT_W-1:0]  BAUD_INT_RESET  = 16'h0000;
   localparam logic [BAUD_BAUD_VALUE_A_W-1:0] BAUD_BAUD_VALUE_A_RESET = 6'h00;
   localparam logic                   BUF_MODE_RESET  = 1'b0;
   localparam logic [IRQ_BITS-1:0]    IRQ_MASK_RESET  = 3'h0;

   // timing counts
   localparam int BAUD_VALUE_A_STEPS      = 64;  // fractional steps per divisor unit
   localparam int SIR_PULSE_TICKS = 3;   // low power pulse length in sir periods
   localparam int RX_ACCEPT_CYC   = 2;   // high cycles a valid ir pulse must exceed

   // sir pulse generator states
   typedef enum logic [2:0] {
      SIR_IDLE  = 3'b001,
      SIR_ARM   = 3'b010,
      SIR_PULSE = 3'b100
   } sir_state_e;
endpackage

/* verilog/uart_flags_baud.sv */
// serial port fifo flags, baud and sir clock generation with wishbone registers
// Notes on behaviour
// - reset clears full, sets empties; busy then follows the shifter idle input
// - bit 7 shows transmit buffer empty
// - bit 6 shows receive buffer full
// - bit 5 shows transmit buffer full
// - bit 4 shows receive buffer empty
// - busy rises once transmit buffer non-empty
// - busy holds until shifter sends stop bits
// - zero low power divisor gives no ticks
// - sir clock is reference over divisor plus one
// - low power pulse lasts three sir periods
// - ir receiver rejects short noise pulses
// - integer divisor is 16 bits, resets zero
// - tick rate is reference over int+baud_value_a/64
// - fraction spread over 64 step cycle
// - buffer mode bit selects fifo or holding
// - data port write pushes transmit character
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module uart_flags_baud
   import uart_flags_pkg::*;
#(
   parameter int DEPTH   = 16,
   parameter int TX_W    = 8,
   parameter int RX_W    = 12
) (
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic            ce_i,
   input  wire logic            cyc_i,
   input  wire logic            stb_i,
   input  wire logic            we_i,
   input  wire logic [11:0]     adr_i,
   input  wire logic [3:0]      sel_i,
   input  wire logic [31:0]     dat_i,
   output logic      [31:0]     dat_o,
   output logic                 ack_o,
   output logic                 irq_o,
   output logic [TX_W-1:0]      tx_data_o,
   output logic                 tx_valid_o,
   input  wire logic            tx_pop_i,
   input  wire logic            tx_shift_idle_i,
   input  wire logic [RX_W-1:0] rx_data_i,
   input  wire logic            rx_push_i,
   output logic                 buffer_mode_o,
   output logic                 baud16_tick_o,
   output logic                 sir_low_power_tick_o,
   input  wire logic            sir_tx_start_i,
   output logic                 sir_pulse_o,
   input  wire logic            ir_rx_i,
   output logic                 ir_rx_valid_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int DW = BAUD_INT_W + BAUD_BAUD_VALUE_A_W;

   // refuse depths the pointer wrap cannot serve
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || TX_W > 32 || RX_W > 32) begin : g_chk
      $error("uart_flags_baud: DEPTH must be a power of two >= 2, widths <= 32");
   end

   // pointer advance with wrap
   function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
      ptr_next = p + 1'b1;
   endfunction

   // byte lane merge for register writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      for (int b = 0; b < 4; b++) begin
         lane_merge[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
      end
   endfunction

   logic                   ack_q;
   logic [31:0]            dat_q;
   logic [LP_DIV_W-1:0]    lp_div_q;
   logic [BAUD_INT_W-1:0]  baud_int_q;
   logic [BAUD_BAUD_VALUE_A_W-1:0] baud_baud_value_a_q;
   logic                   buf_mode_q;
   logic [IRQ_BITS-1:0]    irq_stat_q;
   logic [IRQ_BITS-1:0]    irq_mask_q;
   logic [IRQ_BITS-1:0]    irq_set;
   logic [IRQ_BITS-1:0]    irq_clr;
   logic [TX_W-1:0]        tx_mem [DEPTH];
   logic [RX_W-1:0]        rx_mem [DEPTH];
   logic [AW-1:0]          tx_wr_q;
   logic [AW-1:0]          tx_rd_q;
   logic [AW-1:0]          rx_wr_q;
   logic [AW-1:0]          rx_rd_q;
   logic [CW-1:0]          tx_cnt_q;
   logic [CW-1:0]          rx_cnt_q;
   logic [CW-1:0]          cap;
   logic                   tx_empty;
   logic                   tx_full;
   logic                   rx_empty;
   logic                   rx_full;
   logic                   busy;
   logic [31:0]            flags;
   logic                   req;
   logic                   acc;
   logic [11:0]            ofs;
   logic                   tx_push;
   logic                   tx_pop;
   logic                   rx_push;
   logic                   rx_pop;
   logic                   rx_overrun;
   logic [31:0]            rd_val;
   logic [DW:0]            baud_acc_q;
   logic [DW:0]            baud_sum;
   logic [DW-1:0]          baud_div;
   logic                   baud_tick_q;
   logic [LP_DIV_W-1:0]    lp_cnt_q;
   logic                   lp_tick_q;
   sir_state_e             sir_state_q;
   logic [1:0]             sir_ticks_q;
   logic [1:0]             ir_hi_q;
   logic                   ir_valid_q;

   // bus decode: request taken with ack low, actions at the edge master sees ack
   assign ofs  = {adr_i[11:2], 2'b00};
   assign req  = cyc_i && stb_i && !ack_q;
   assign acc  = cyc_i && stb_i && ack_q;
   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // buffer capacity follows buffer mode: full depth or one holding entry
   assign cap      = buf_mode_q ? CW'(DEPTH) : CW'(1);
   assign tx_empty = (tx_cnt_q == '0);
   assign tx_full  = (tx_cnt_q >= cap);
   assign rx_empty = (rx_cnt_q == '0);
   assign rx_full  = (rx_cnt_q >= cap);
   assign busy     = !tx_empty || !tx_shift_idle_i;

   // flag word, reserved bits zero
   always_comb begin
      flags               = 32'h0000_0000;
      flags[TX_EMPTY_BIT] = tx_empty;
      flags[RX_FULL_BIT]  = rx_full;
      flags[TX_FULL_BIT]  = tx_full;
      flags[RX_EMPTY_BIT] = rx_empty;
      flags[BUSY_BIT]     = busy;
   end

   // fifo traffic
   assign tx_push    = ce_i && acc && we_i && ofs == OFS_DATA_PORT && sel_i[0] && !tx_full;
   assign tx_pop     = ce_i && tx_pop_i && !tx_empty;
   assign rx_pop     = ce_i && acc && !we_i && ofs == OFS_DATA_PORT && !rx_empty;
   assign rx_push    = ce_i && rx_push_i && (!rx_full || rx_pop);
   assign rx_overrun = ce_i && rx_push_i && rx_full && !rx_pop;
   assign tx_valid_o = !tx_empty;
   assign tx_data_o  = tx_mem[tx_rd_q];
   assign buffer_mode_o = buf_mode_q;

   // read mux; flag read only samples state
   always_comb begin
      rd_val = 32'h0000_0000;
      case (ofs)
         OFS_DATA_PORT:   rd_val[RX_W-1:0] = rx_mem[rx_rd_q];
         OFS_FIFO_FLAGS:  rd_val = flags;
         OFS_IRDA_LP_DIV: rd_val[LP_DIV_W-1:0] = lp_div_q;
         OFS_BAUD_INT:    rd_val[BAUD_INT_W-1:0] = baud_int_q;
         OFS_BAUD_BAUD_VALUE_A:   rd_val[BAUD_BAUD_VALUE_A_W-1:0] = baud_baud_value_a_q;
         OFS_LINE_CTRL:   rd_val[BUFFER_MODE_BIT] = buf_mode_q;
         OFS_IRQ_STATUS:  rd_val[IRQ_BITS-1:0] = irq_stat_q;
         OFS_IRQ_MASK:    rd_val[IRQ_BITS-1:0] = irq_mask_q;
         default:         rd_val = 32'h0000_0000;
      endcase
   end

   // bus handshake and read data capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q <= req;
         if (req && !we_i) begin
            dat_q <= rd_val;
         end
      end
   end

   // software registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lp_div_q    <= LP_DIV_RESET;
         baud_int_q  <= BAUD_INT_RESET;
         baud_baud_value_a_q <= BAUD_BAUD_VALUE_A_RESET;
         buf_mode_q  <= BUF_MODE_RESET;
         irq_mask_q  <= IRQ_MASK_RESET;
      end else if (ce_i && acc && we_i) begin
         case (ofs)
            OFS_IRDA_LP_DIV: lp_div_q <= LP_DIV_W'(lane_merge(32'(lp_div_q), dat_i, sel_i));
            OFS_BAUD_INT:    baud_int_q <= BAUD_INT_W'(lane_merge(32'(baud_int_q), dat_i, sel_i));
            OFS_BAUD_BAUD_VALUE_A:   baud_baud_value_a_q <= BAUD_BAUD_VALUE_A_W'(lane_merge(32'(baud_baud_value_a_q), dat_i,
                                                                    sel_i));
            OFS_LINE_CTRL:   buf_mode_q <= sel_i[0] ? dat_i[BUFFER_MODE_BIT] : buf_mode_q;
            OFS_IRQ_MASK:    irq_mask_q <= sel_i[0] ? dat_i[IRQ_BITS-1:0] : irq_mask_q;
            default:         buf_mode_q <= buf_mode_q;
         endcase
      end
   end

   // transmit buffer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_wr_q  <= '0;
         tx_rd_q  <= '0;
         tx_cnt_q <= '0;
      end else begin
         if (tx_push) begin
            tx_mem[tx_wr_q] <= dat_i[TX_W-1:0];
            tx_wr_q         <= ptr_next(tx_wr_q);
         end
         if (tx_pop) begin
            tx_rd_q <= ptr_next(tx_rd_q);
         end
         tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
      end
   end

   // receive buffer; a push into a full buffer with no pop that cycle is dropped as overrun
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_wr_q  <= '0;
         rx_rd_q  <= '0;
         rx_cnt_q <= '0;
      end else begin
         if (rx_push) begin
            rx_mem[rx_wr_q] <= rx_data_i;
            rx_wr_q         <= ptr_next(rx_wr_q);
         end
         if (rx_pop) begin
            rx_rd_q <= ptr_next(rx_rd_q);
         end
         rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
      end
   end

   // sticky event bits; a read clears only the bits it returned, a new set wins
   always_comb begin
      irq_set                     = '0;
      irq_set[IRQ_TX_DRAINED_BIT] = tx_pop && tx_cnt_q == CW'(1) && !tx_push;
      irq_set[IRQ_RX_DATA_BIT]    = rx_push;
      irq_set[IRQ_RX_OVERRUN_BIT] = rx_overrun;
      irq_clr                     = '0;
      if (acc && !we_i && ofs == OFS_IRQ_STATUS) begin
         irq_clr = dat_q[IRQ_BITS-1:0];
      end
   end
   // status register update
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
      end else if (ce_i) begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      end
   end
   assign irq_o = |(irq_stat_q & irq_mask_q);

   // fractional baud: add 64 per cycle, tick on reaching int*64+baud_value_a
   assign baud_div = {baud_int_q, baud_baud_value_a_q};
   assign baud_sum = baud_acc_q + (DW+1)'(BAUD_VALUE_A_STEPS);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         baud_acc_q  <= '0;
         baud_tick_q <= 1'b0;
      end else if (ce_i) begin
         if (baud_div == '0) begin
            baud_acc_q  <= '0;
            baud_tick_q <= 1'b0;
         end else if (baud_sum >= {1'b0, baud_div}) begin
            baud_tick_q <= 1'b1;
            // a divisor written below the running sum restarts the phase: no tick burst
            if (baud_div < DW'(BAUD_VALUE_A_STEPS) || baud_acc_q >= {1'b0, baud_div}) begin
               baud_acc_q <= '0;
            end else begin
               baud_acc_q <= baud_sum - {1'b0, baud_div};
            end
         end else begin
            baud_tick_q <= 1'b0;
            baud_acc_q  <= baud_sum;
         end
      end
   end
   assign baud16_tick_o = baud_tick_q;

   // sir low power clock: one tick every divisor+1 reference cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lp_cnt_q  <= '0;
         lp_tick_q <= 1'b0;
      end else if (ce_i) begin
         if (lp_div_q == '0) begin
            lp_cnt_q  <= '0;
            lp_tick_q <= 1'b0;
         end else if (lp_cnt_q >= lp_div_q) begin
            lp_cnt_q  <= '0;
            lp_tick_q <= 1'b1;
         end else begin
            lp_cnt_q  <= lp_cnt_q + 1'b1;
            lp_tick_q <= 1'b0;
         end
      end
   end
   assign sir_low_power_tick_o = lp_tick_q;

   // low power pulse: aligned to a sir tick, three sir periods long
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sir_state_q <= SIR_IDLE;
         sir_ticks_q <= '0;
      end else if (ce_i) begin
         case (sir_state_q)
            SIR_IDLE: begin
               if (sir_tx_start_i && lp_div_q != '0) begin
                  sir_state_q <= SIR_ARM;
               end
            end
            SIR_ARM: begin
               if (lp_tick_q) begin
                  sir_state_q <= SIR_PULSE;
                  sir_ticks_q <= '0;
               end
            end
            SIR_PULSE: begin
               if (lp_tick_q) begin
                  if (sir_ticks_q == 2'(SIR_PULSE_TICKS - 1)) begin
                     sir_state_q <= SIR_IDLE;
                  end else begin
                     sir_ticks_q <= sir_ticks_q + 1'b1;
                  end
               end
            end
            default: sir_state_q <= SIR_IDLE;
         endcase
      end
   end
   assign sir_pulse_o = (sir_state_q == SIR_PULSE);

   // ir receive filter: accept only pulses high for more than two cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ir_hi_q    <= '0;
         ir_valid_q <= 1'b0;
      end else if (ce_i) begin
         ir_hi_q    <= !ir_rx_i ? '0 : (ir_hi_q == 2'(RX_ACCEPT_CYC)) ? ir_hi_q : ir_hi_q + 1'b1;
         ir_valid_q <= ir_rx_i && ir_hi_q == 2'(RX_ACCEPT_CYC);
      end
   end
   assign ir_rx_valid_o = ir_valid_q;

   // checks
   a_flags_after_reset: assert property (@(posedge clk_i)
      $fell(rst_i) |-> (flags[TX_EMPTY_BIT] && flags[RX_EMPTY_BIT] && !flags[TX_FULL_BIT]
                        && !flags[RX_FULL_BIT]))
      else $error("flags wrong after reset");
   a_tx_empty_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_push && tx_empty) |=> !flags[TX_EMPTY_BIT])
      else $error("tx empty flag stayed after push");
   a_rx_full_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_push && !rx_pop && rx_cnt_q == cap - 1'b1 && !(acc && we_i)) |=> flags[RX_FULL_BIT])
      else $error("rx full flag missing");
   a_tx_full_char: assert property (@(posedge clk_i) disable iff (rst_i)
      (!buf_mode_q && tx_push && !tx_pop && !(acc && we_i && ofs == OFS_LINE_CTRL))
      |=> flags[TX_FULL_BIT])
      else $error("holding register full flag missing");
   a_rx_empty_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_pop && !rx_push && rx_cnt_q == CW'(1)) |=> flags[RX_EMPTY_BIT])
      else $error("rx empty flag missing");
   a_busy_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      (!tx_shift_idle_i || tx_push) |=> (flags[BUSY_BIT] || tx_shift_idle_i && tx_empty
                                         && !$past(tx_push)))
      else $error("busy dropped early");
   a_no_lp_ticks: assert property (@(posedge clk_i) disable iff (rst_i)
      (lp_div_q == '0)[*2] |-> !sir_low_power_tick_o)
      else $error("sir tick with zero divisor");
   a_ir_filter: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(ir_rx_valid_o) |-> ($past(ir_rx_i, 1) && $past(ir_rx_i, 2) && $past(ir_rx_i, 3)))
      else $error("short ir pulse accepted");
   a_baud_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && baud16_tick_o && baud_div >= DW'(2 * BAUD_VALUE_A_STEPS)) |=> !baud16_tick_o)
      else $error("baud ticks too close");
endmodule
`default_nettype wire

/* verif/serial_shifter_model.sv */
// behavioural transmit shifter standing behind the block's transmit buffer
`timescale 1ns/1ps
`default_nettype none
module serial_shifter_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic [7:0] frame_i,
   input  wire logic       tx_valid_i,
   output logic            tx_pop_o,
   output logic            shift_idle_o
);
   int left;
   initial begin
      tx_pop_o = 1'b0;
      shift_idle_o = 1'b1;
   end
   // take the head when idle, then shift frame_i cycles including stop bits
   always @(posedge clk_i) begin
      tx_pop_o <= 1'b0;
      if (rst_i) begin
         left = 0;
         shift_idle_o <= 1'b1;
      end else if (left > 0) begin
         left--;
         if (left == 0) shift_idle_o <= 1'b1;
      end else if (run_i && tx_valid_i === 1'b1 && !tx_pop_o) begin
         tx_pop_o <= 1'b1;
         shift_idle_o <= 1'b0;
         left = frame_i;
      end
   end
endmodule
`default_nettype wire

/* verif/test_uart_flags_baud.sv */
// self-checking bench for the flag, baud divisor and sir clock block
`timescale 1ns/1ps
`default_nettype none
module test_uart_flags_baud;
   import uart_flags_pkg::*;
   localparam int DEPTH = 8;
   logic        clk_i, rst_i, cyc, stb, we, rx_push, sir_start, ir_rx, run;
   logic        pop, idle, ack, irq, tx_valid, bmode, btick, stick, spulse, irv;
   logic [11:0] adr, rx_data;
   logic [31:0] wdat, rdat, q;
   logic [7:0]  frame, tx_data;
   int          fail_count, n_tests, cyc_n, n_bt, n_st, n_sp, n_iv, tn, rn, i, t, s0;
   bit          fifo;
   logic [7:0]  txq[$], popq[$];
   logic [11:0] rxq[$];

   uart_flags_baud #(.DEPTH(DEPTH)) i_uart_flags_baud (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_o(irq), .tx_data_o(tx_data),
      .tx_valid_o(tx_valid), .tx_pop_i(pop), .tx_shift_idle_i(idle), .rx_data_i(rx_data),
      .rx_push_i(rx_push), .buffer_mode_o(bmode), .baud16_tick_o(btick),
      .sir_low_power_tick_o(stick), .sir_tx_start_i(sir_start), .sir_pulse_o(spulse),
      .ir_rx_i(ir_rx), .ir_rx_valid_o(irv));
   serial_shifter_model i_serial_shifter_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
      .frame_i(frame), .tx_valid_i(tx_valid), .tx_pop_o(pop), .shift_idle_o(idle));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // pulse counters, popped characters and the hang limit
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      n_bt <= n_bt + int'(btick === 1'b1);
      n_st <= n_st + int'(stick === 1'b1);
      n_sp <= n_sp + int'(spulse === 1'b1);
      n_iv <= n_iv + int'(irv === 1'b1);
      if (pop && tx_valid === 1'b1) popq.push_back(tx_data);
      if (cyc_n > 20000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_count(input string what, input int e, input int g);
      n_tests++;
      if (g != e) begin
         fail_count++;
         $display("Error %s expected %0d seen %0d", what, e, g);
      end
   endtask
   // one classic wishbone cycle, released only after ack is sampled
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic int cap();
      return fifo ? DEPTH : 1;
   endfunction
   // flag word expected from the buffer counts and the shifter state
   function automatic logic [31:0] exp_flags();
      logic [31:0] f;
      f = 32'h0;
      f[TX_EMPTY_BIT] = (tn == 0);
      f[RX_FULL_BIT] = (rn >= cap());
      f[TX_FULL_BIT] = (tn >= cap());
      f[RX_EMPTY_BIT] = (rn == 0);
      f[BUSY_BIT] = (tn != 0) || (idle !== 1'b1);
      return f;
   endfunction
   task automatic chk_flags;
      bus(1'b0, OFS_FIFO_FLAGS, 32'h0);
      chk_word("flags", exp_flags(), q);
   endtask
   task automatic put_char(input logic [7:0] c);
      bus(1'b1, OFS_DATA_PORT, {24'h0, c});
      if (tn < cap()) begin
         tn++;
         txq.push_back(c);
      end
   endtask
   // back-to-back receive pushes with random characters
   task automatic push_rx(input int n);
      logic [11:0] d;
      for (int k = 0; k < n; k++) begin
         d = 12'($urandom_range(0, 255));
         rx_data <= d;
         rx_push <= 1'b1;
         if (rn < cap()) begin
            rn++;
            rxq.push_back(d);
         end
         @(posedge clk_i);
      end
      rx_push <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic pop_rx;
      bus(1'b0, OFS_DATA_PORT, 32'h0);
      chk_word("rx data", {20'h0, rxq.pop_front()}, q);
      rn--;
   endtask
   // let the shifter empty the transmit buffer, checking busy meanwhile
   task automatic drain(input logic [7:0] f);
      frame <= f;
      run <= 1'b1;
      for (t = 0; tx_valid !== 1'b0 && t < 1000; t++) @(posedge clk_i);
      run <= 1'b0;
      tn = 0;
      if (f > 8) chk_flags();
      for (t = 0; idle !== 1'b1 && t < 100; t++) @(posedge clk_i);
      chk_flags();
      chk_count("popped", txq.size(), popq.size());
      while (txq.size() > 0 && popq.size() > 0) begin
         chk_word("tx data", txq.pop_front(), popq.pop_front());
      end
   endtask

   initial begin
      {cyc, stb, we, rx_push, sir_start, ir_rx, run, adr, wdat, rx_data} = '0;
      {fail_count, n_tests, cyc_n, n_bt, n_st, n_sp, n_iv, tn, rn} = '0;
      frame = 8'h28;
      fifo = 1'b0;
      rst_i = 1'b1;
      void'($urandom(37978));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_flags();
      bus(1'b0, OFS_IRDA_LP_DIV, 32'h0);
      chk_word("lp divisor", 32'h0, q);
      bus(1'b0, OFS_BAUD_INT, 32'h0);
      chk_word("baud int", 32'h0, q);
      bus(1'b1, OFS_BAUD_INT, 32'hffffffff);
      bus(1'b0, OFS_BAUD_INT, 32'h0);
      chk_word("baud int", 32'h0000ffff, q);
      bus(1'b1, OFS_BAUD_BAUD_VALUE_A, 32'hffffffff);
      bus(1'b0, OFS_BAUD_BAUD_VALUE_A, 32'h0);
      chk_word("baud baud_value_a", 32'h0000003f, q);
      bus(1'b1, OFS_IRDA_LP_DIV, 32'hffffffff);
      bus(1'b0, OFS_IRDA_LP_DIV, 32'h0);
      chk_word("lp divisor", 32'h000000ff, q);
      bus(1'b1, 12'h100, 32'hffffffff);
      bus(1'b0, 12'h100, 32'h0);
      chk_word("unmapped", 32'h0, q);
      // character mode: one-entry holding registers and the receive interrupt
      bus(1'b1, OFS_IRQ_MASK, 32'h2);
      push_rx(1);
      repeat (2) @(posedge clk_i);
      chk_word("irq", 32'h1, {31'h0, irq});
      bus(1'b0, OFS_IRQ_STATUS, 32'h0);
      chk_word("irq status", 32'h2, q);
      @(posedge clk_i);
      chk_word("irq", 32'h0, {31'h0, irq});
      chk_flags();
      push_rx(1);
      chk_flags();
      pop_rx();
      chk_flags();
      put_char(8'h55);
      chk_flags();
      put_char(8'haa);
      chk_flags();
      drain(8'h28);
      // drained and overrun events stay sticky until read
      bus(1'b0, OFS_IRQ_STATUS, 32'h0);
      chk_word("irq status", 32'h5, q);
      // fifo mode: fill both buffers past capacity, then empty them
      bus(1'b1, OFS_LINE_CTRL, 32'h10);
      fifo = 1'b1;
      chk_word("buffer mode", 32'h1, {31'h0, bmode});
      for (i = 0; i <= DEPTH; i++) begin
         put_char(8'($urandom()));
         chk_flags();
      end
      push_rx(DEPTH + 1);
      chk_flags();
      for (i = 0; i < DEPTH; i++) pop_rx();
      chk_flags();
      drain(8'h2);
      bus(1'b1, OFS_IRQ_MASK, 32'h0);
      push_rx(1);
      repeat (2) @(posedge clk_i);
      chk_word("irq", 32'h0, {31'h0, irq});
      pop_rx();
      // baud tick over two periods of the combined divisor, then divisor zero
      for (i = 0; i < 4; i++) begin
         tn = (i < 3) ? $urandom_range(1, 3) : 0;
         rn = (i < 3) ? $urandom_range(0, 63) : 0;
         bus(1'b1, OFS_BAUD_INT, 32'(tn));
         bus(1'b1, OFS_BAUD_BAUD_VALUE_A, 32'(rn));
         t = (i < 3) ? tn * 64 + rn : 150;
         repeat (t) @(posedge clk_i);
         s0 = n_bt;
         repeat (2 * t) @(posedge clk_i);
         chk_count("baud ticks", (i < 3) ? 128 : 0, n_bt - s0);
      end
      tn = 0;
      rn = 0;
      // sir clock period is divisor plus one; zero gives none
      for (i = 0; i < 3; i++) begin
         s0 = (i == 0) ? 0 : $urandom_range(1, 9);
         bus(1'b1, OFS_IRDA_LP_DIV, 32'(s0));
         repeat (20) @(posedge clk_i);
         t = n_st;
         repeat ((i == 0) ? 40 : 4 * (s0 + 1)) @(posedge clk_i);
         chk_count("sir ticks", (i == 0) ? 0 : 4, n_st - t);
      end
      // divisor for a sir clock near the nominal rate: period of 27 reference cycles
      bus(1'b1, OFS_IRDA_LP_DIV, 32'h1a);
      sir_start <= 1'b1;
      @(posedge clk_i);
      sir_start <= 1'b0;
      s0 = n_sp;
      repeat (120) @(posedge clk_i);
      chk_count("sir pulse", SIR_PULSE_TICKS * 27, n_sp - s0);
      // short ir glitch is dropped, a long pulse passes
      for (i = 1; i < 7; i += 5) begin
         s0 = n_iv;
         ir_rx <= 1'b1;
         repeat (i) @(posedge clk_i);
         ir_rx <= 1'b0;
         repeat (6) @(posedge clk_i);
         chk_count("ir valid", int'(i > 2), int'(n_iv > s0));
      end
      end_sim();
   end
endmodule
`default_nettype wire
